// file: core/enhanced_timer.sv
/*
  Enhanced timer: 10-bit up/down counter, period comparator, two compare
  channels with compare-match, PWM, single-pulse and capture pin functions,
  and an APB register slave.
  Assumes ref_clk_in is both system and high-speed clock; the subsidiary
  and external clocks and the channel pins come in asynchronously.
*/
`timescale 1ns/1ps
`include "enhanced_timer_params.svh"

module enhanced_timer
  import enhanced_timer_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // Register bus
  input  wire apb_req_s   apb_in,
  output apb_rsp_s        apb_out,
  // Clock pins
  input  wire logic       external_clock_pin_in,
  input  wire logic       subsidiary_clock_in,
  // Channel A pins (enable low while driving)
  input  wire logic [1:0] chan_a_pin_in,
  output logic [1:0]      chan_a_pin_out,
  output logic [1:0]      chan_a_pin_oe_n_out,
  // Channel B pins (enable low while driving)
  input  wire logic [2:0] chan_b_pin_in,
  output logic [2:0]      chan_b_pin_out,
  output logic [2:0]      chan_b_pin_oe_n_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and their fields
  logic [7:0]   clock_run_q;        // Pause, clock select, on, period
  logic [7:0]   chan_a_ctrl_q;      // Mode, pin function, level, invert
  logic [7:0]   chan_b_ctrl_q;      // Mode, pin function, level, alignment
  logic [2:0]   flags_q;            // Sticky match flags: period, B, A
  logic [9:0]   cnt_q;              // Counter
  logic         down_q;             // Counting direction
  logic         on_prev_q;          // Timer on, one cycle late
  logic [5:0]   presc_q;            // Free prescaler
  logic [2:0]   ext_sync_q;         // External clock synchroniser and history
  logic [2:0]   sub_sync_q;         // Subsidiary clock synchroniser and history
  logic [9:0]   cmp_w [2];          // Compare values per channel
  logic [1:0]   lvl_w;              // Channel levels before inversion
  logic [1:0]   drive_w;            // Channel drives its pins
  logic [1:0]   hit_w;              // Channel comparator matches
  logic [1:0]   cap_w;              // Channel capture events

  logic         counter_pause;      // Pause control
  clock_sel_e   counter_clock_select; // Clock source
  logic         timer_on;           // Overall on
  logic [2:0]   period_compare_value; // Period comparator value
  logic         counter_clear_select; // Clear on comparator A
  logic [1:0]   pwm_alignment;      // PWM alignment
  chan_mode_e   mode_w [2];         // Channel modes
  logic [1:0]   fn_w [2];           // Channel pin functions
  logic [1:0]   oc_w;               // Channel output control bits
  logic [1:0]   inv_w;              // Channel invert bits

  assign counter_pause        = clock_run_q[`BIT_PAUSE];
  assign counter_clock_select = clock_sel_e'(clock_run_q[6:4]);
  assign timer_on             = clock_run_q[`BIT_ON];
  assign period_compare_value = clock_run_q[2:0];
  assign counter_clear_select = chan_a_ctrl_q[`BIT_CLR_SEL];
  assign pwm_alignment        = chan_b_ctrl_q[1:0];
  assign mode_w[0] = chan_mode_e'(chan_a_ctrl_q[7:6]);
  assign mode_w[1] = chan_mode_e'(chan_b_ctrl_q[7:6]);
  assign fn_w[0]   = chan_a_ctrl_q[5:4];
  assign fn_w[1]   = chan_b_ctrl_q[5:4];
  assign oc_w      = {chan_b_ctrl_q[3], chan_a_ctrl_q[3]};
  assign inv_w     = {chan_b_ctrl_q[2], chan_a_ctrl_q[2]};

  ////////////////////////////////////////////////////////////////////////////
  // Counter clock selection
  logic tick;                        // One counting step due
  logic on_rise;                     // Timer switched on this cycle
  logic step;                        // Counter advances this cycle

  // Prescaler runs free so the divided clocks keep their phase
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      presc_q <= 6'h00;
    end else begin
      presc_q <= presc_q + 6'h01;
    end
  end

  // Two-stage synchronisers, third stage only for edge detection
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_sync_q <= 3'h0;
      sub_sync_q <= 3'h0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], external_clock_pin_in};
      sub_sync_q <= {sub_sync_q[1:0], subsidiary_clock_in};
    end
  end

  // Tick from the selected source; code 101 gives none
  always_comb begin
    case (counter_clock_select)
      CK_SYS_DIV4: tick = (presc_q[1:0] == `PRESC_DIV4);
      CK_SYS:      tick = 1'b1;
      CK_HI_DIV16: tick = (presc_q[3:0] == `PRESC_DIV16);
      CK_HI_DIV64: tick = (presc_q == `PRESC_MAX);
      CK_SUB:      tick = sub_sync_q[1] & ~sub_sync_q[2];
      CK_EXT_RISE: tick = ext_sync_q[1] & ~ext_sync_q[2];
      CK_EXT_FALL: tick = ~ext_sync_q[1] & ext_sync_q[2];
      default:     tick = 1'b0;
    endcase
  end

  assign on_rise = timer_on & ~on_prev_q;
  assign step    = timer_on & ~counter_pause & tick & ~on_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Comparators and clear source
  logic [9:0] period_top;            // Period comparator point
  logic       per_hit;               // Period match or overflow
  logic       clear_on_a;            // Comparator A clears the counter
  logic       centre;                // Centre-aligned counting
  logic [9:0] top;                   // Turning or clearing point

  // Matches fall on multiples of 128; zero means full range
  assign period_top = (period_compare_value == 3'h0) ? `COUNT_MAX :
                      {period_compare_value, `PERIOD_LOW_ZERO};
  assign per_hit    = step & (cnt_q == period_top);
  // Clear select has no meaning in pulse or capture operation beyond masking the period flag
  assign clear_on_a = counter_clear_select &
                      ~(mode_w[0] == MODE_CAPTURE) &
                      ~(mode_w[0] == MODE_PWM && fn_w[0] == 2'h3);
  assign centre     = (pwm_alignment != 2'h0) &
                      ((mode_w[0] == MODE_PWM) | (mode_w[1] == MODE_PWM));
  assign top        = clear_on_a ? cmp_w[0] : period_top;

  ////////////////////////////////////////////////////////////////////////////
  // Counter and direction
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q     <= `CMP_RESET;
      down_q    <= 1'b0;
      on_prev_q <= 1'b0;
    end else begin
      on_prev_q <= timer_on;
      if (on_rise) begin
        cnt_q  <= `CMP_RESET;
        down_q <= 1'b0;
      end else if (step && centre) begin
        // Centre alignment turns at the top and at zero
        if (!down_q && cnt_q == top) begin
          cnt_q  <= cnt_q - 10'h001;
          down_q <= 1'b1;
        end else if (down_q && cnt_q == 10'h000) begin
          cnt_q  <= 10'h001;
          down_q <= 1'b0;
        end else begin
          cnt_q <= down_q ? cnt_q - 10'h001 : cnt_q + 10'h001;
        end
      end else if (step) begin
        // Edge alignment clears at the chosen point, wraps at full range
        down_q <= 1'b0;
        cnt_q  <= (cnt_q == top) ? `CMP_RESET : cnt_q + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus write decode
  logic       wr_en;                 // Write takes effect now
  logic [1:0] cmp_wr;                // Write to a compare register

  assign wr_en     = apb_in.psel & apb_in.penable & apb_in.pwrite & apb_out.pready;
  assign cmp_wr[0] = wr_en & (apb_in.paddr == `OFS_COMPARE_A);
  assign cmp_wr[1] = wr_en & (apb_in.paddr == `OFS_COMPARE_B);

  ////////////////////////////////////////////////////////////////////////////
  // Channels: compare value, capture and output level
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic [9:0] cmp_q;             // Compare or captured value
      logic       lvl_q;             // Pin level before inversion
      logic       pulse_q;           // Single pulse still active
      logic [2:0] pins_s1_q;         // First synchroniser stage
      logic [2:0] pins_s2_q;         // Second synchroniser stage
      logic [2:0] pins_s3_q;         // History for edges
      logic       rise;              // Rising edge on any pin
      logic       fall;              // Falling edge on any pin
      logic       dir_ok;            // Match direction accepted
      logic       active;            // PWM active phase

      // Pin inputs cross into the clock domain
      always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
          pins_s1_q <= 3'h0;
          pins_s2_q <= 3'h0;
          pins_s3_q <= 3'h0;
        end else begin
          pins_s1_q <= (ch == 0) ? {1'b0, chan_a_pin_in} : chan_b_pin_in;
          pins_s2_q <= pins_s1_q;
          pins_s3_q <= pins_s2_q;
        end
      end

      assign rise = |(pins_s2_q & ~pins_s3_q);
      assign fall = |(~pins_s2_q & pins_s3_q);
      assign hit_w[ch] = step & (cnt_q == cmp_q);
      // Capture edge choice; 10 takes both edges
      always_comb begin
        case (fn_w[ch])
          2'h0:    cap_w[ch] = rise;
          2'h1:    cap_w[ch] = fall;
          2'h2:    cap_w[ch] = rise | fall;
          default: cap_w[ch] = 1'b0;
        endcase
        if (!(timer_on && mode_w[ch] == MODE_CAPTURE)) begin
          cap_w[ch] = 1'b0;
        end
      end

      // Captured counter value wins over a bus write
      always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
          cmp_q <= `CMP_RESET;
        end else if (cap_w[ch]) begin
          cmp_q <= cnt_q;
        end else if (cmp_wr[ch]) begin
          cmp_q <= apb_in.pwdata[9:0];
        end
      end

      // Centre matches count only in the chosen direction
      assign dir_ok = (pwm_alignment == 2'h3) |
                      (pwm_alignment == 2'h1 && !down_q) |
                      (pwm_alignment == 2'h2 && down_q);

      // Active phase of the PWM or pulse functions
      always_comb begin
        case (fn_w[ch])
          2'h0:    active = 1'b0;
          2'h1:    active = 1'b1;
          2'h2:    active = centre ? (lvl_q == oc_w[ch]) : (cnt_q < cmp_q);
          default: active = pulse_q;
        endcase
        if (fn_w[ch] == 2'h2 && centre && hit_w[ch] && dir_ok) begin
          active = ~active;
        end
      end

      // Compare level follows A or B matches only, never the period match; edge PWM level also turns at the counter wrap
      always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
          lvl_q   <= 1'b0;
          pulse_q <= 1'b0;
        end else if (on_rise) begin
          lvl_q   <= (mode_w[ch] == MODE_PWM) ? ~oc_w[ch] : oc_w[ch];
          pulse_q <= 1'b1;
        end else if (mode_w[ch] == MODE_COMPARE && hit_w[ch]) begin
          case (fn_w[ch])
            2'h1:    lvl_q <= 1'b0;
            2'h2:    lvl_q <= 1'b1;
            2'h3:    lvl_q <= ~lvl_q;
            default: lvl_q <= lvl_q;
          endcase
        end else if (mode_w[ch] == MODE_PWM) begin
          // Active level set by the output control bit
          lvl_q <= active ? oc_w[ch] : ~oc_w[ch];
          if (hit_w[ch]) begin
            pulse_q <= 1'b0;
          end
        end
      end

      assign cmp_w[ch] = cmp_q;
      assign lvl_w[ch] = lvl_q;
      // Capture and timer modes leave pins free; A idle in PWM when A sets period, still driven in compare
      assign drive_w[ch] = (mode_w[ch] == MODE_COMPARE) |
                           (mode_w[ch] == MODE_PWM && !(ch == 0 && clear_on_a));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs, inverted per channel
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      chan_a_pin_out      <= 2'h0;
      chan_b_pin_out      <= 3'h0;
      chan_a_pin_oe_n_out <= 2'h3;
      chan_b_pin_oe_n_out <= 3'h7;
    end else begin
      chan_a_pin_out      <= {2{lvl_w[0] ^ inv_w[0]}};
      chan_b_pin_out      <= {3{lvl_w[1] ^ inv_w[1]}};
      chan_a_pin_oe_n_out <= {2{~drive_w[0]}};
      chan_b_pin_oe_n_out <= {3{~drive_w[1]}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky match flags; hardware set wins over a bus clear
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_q <= 3'h0;
    end else begin
      flags_q <= (flags_q & ~((wr_en && apb_in.paddr == `OFS_FLAGS) ?
                              apb_in.pwdata[2:0] : 3'h0))
                 | {per_hit & ~counter_clear_select,
                    hit_w[1] | cap_w[1], hit_w[0] | cap_w[0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register writes; direction bit stays read-only
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clock_run_q   <= `CTRL_RESET;
      chan_a_ctrl_q <= `CTRL_RESET;
      chan_b_ctrl_q <= `CTRL_RESET;
    end else if (wr_en) begin
      case (apb_in.paddr)
        `OFS_CLOCK_RUN: clock_run_q   <= apb_in.pwdata[7:0];
        `OFS_CHAN_A:    chan_a_ctrl_q <= apb_in.pwdata[7:0];
        `OFS_CHAN_B:    chan_b_ctrl_q <= apb_in.pwdata[7:0];
        default:        clock_run_q   <= clock_run_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: data latched in the setup cycle, ready in the access cycle
  logic [31:0] rd_mux;               // Read data for the addressed word
  logic        unmapped;             // No register at the address

  always_comb begin
    rd_mux   = 32'h0000_0000;
    unmapped = 1'b0;
    case (apb_in.paddr)
      `OFS_CLOCK_RUN: rd_mux[7:0] = clock_run_q;
      `OFS_CHAN_A:    rd_mux[7:0] = {chan_a_ctrl_q[7:2], down_q,
                                     chan_a_ctrl_q[0]};
      `OFS_CHAN_B:    rd_mux[7:0] = chan_b_ctrl_q;
      `OFS_COUNT:     rd_mux[9:0] = cnt_q;
      `OFS_COMPARE_A: rd_mux[9:0] = cmp_w[0];
      `OFS_COMPARE_B: rd_mux[9:0] = cmp_w[1];
      `OFS_FLAGS:     rd_mux[2:0] = flags_q;
      default:        unmapped    = 1'b1;
    endcase
  end

  // One wait-free access phase per transfer
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      apb_out <= '0;
    end else begin
      apb_out.pready  <= apb_in.psel & ~apb_in.penable;
      apb_out.pslverr <= apb_in.psel & ~apb_in.penable & unmapped;
      if (apb_in.psel && !apb_in.penable) begin
        apb_out.prdata <= apb_in.pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

endmodule

// file: core/enhanced_timer_params.svh
/*
  Offsets, field positions, reset values and counts of the enhanced timer.
  Assumes inclusion by bare name from the package and the timer module.
*/
`ifndef ENHANCED_TIMER_PARAMS_SVH
`define ENHANCED_TIMER_PARAMS_SVH
// Register byte addresses
`define OFS_CLOCK_RUN    8'h00
`define OFS_CHAN_A       8'h04
`define OFS_CHAN_B       8'h08
`define OFS_COUNT        8'h0C
`define OFS_COMPARE_A    8'h10
`define OFS_COMPARE_B    8'h14
`define OFS_FLAGS        8'h18
// Reset values
`define CTRL_RESET       8'h00
`define CMP_RESET        10'h000
// Fields of the clock and run register
`define BIT_PAUSE        7
`define BIT_ON           3
// Fields of the channel A register
`define BIT_CLR_SEL      0
`define BIT_DIR          1
// Counter limits and the period comparator step
`define COUNT_MAX        10'h3FF
`define PERIOD_LOW_ZERO  7'h00
`define PRESC_MAX        6'h3F
`define PRESC_DIV4       2'h3
`define PRESC_DIV16      4'hF
`endif

// file: core/enhanced_timer_pkg.sv
/*
  Types of the enhanced timer: bus carriers and field encodings.
  Assumes the parameter header is on the include path.
*/
package enhanced_timer_pkg;
  `include "enhanced_timer_params.svh"
  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  // APB answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;
  // Channel operating modes
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_CAPTURE = 2'h1,
    MODE_PWM     = 2'h2,
    MODE_TIMER   = 2'h3
  } chan_mode_e;
  // Counter clock sources
  typedef enum logic [2:0] {
    CK_SYS_DIV4 = 3'h0,
    CK_SYS      = 3'h1,
    CK_HI_DIV16 = 3'h2,
    CK_HI_DIV64 = 3'h3,
    CK_SUB      = 3'h4,
    CK_NONE     = 3'h5,
    CK_EXT_RISE = 3'h6,
    CK_EXT_FALL = 3'h7
  } clock_sel_e;
endpackage

// file: tb/enhanced_timer_props.sv
/*
  Port checker for the enhanced timer: bus timing, register readback, pin drive.
  Assumes binding into enhanced_timer; mirrors control writes seen on the bus.
*/
`timescale 1ns/1ps
module enhanced_timer_props
  import enhanced_timer_pkg::*;
(
  // Clock and reset
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  // Register bus
  input wire apb_req_s   apb_in,
  input wire apb_rsp_s   apb_out,
  // Pins
  input wire logic [1:0] chan_a_pin_out,
  input wire logic [1:0] chan_a_pin_oe_n_out,
  input wire logic [2:0] chan_b_pin_oe_n_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic [7:0] ctrl_q;  // Mirror of clock/run register
  logic [7:0] cha_q;   // Mirror of channel A register
  logic [7:0] chb_q;   // Mirror of channel B register
  logic       acc;     // Access phase
  logic       done;    // Completed mapped transfer
  assign acc  = apb_in.psel && apb_in.penable;
  assign done = acc && apb_out.pready && !apb_out.pslverr;
  ////////////////////////////////////////////////////////////////////////////
  // Shadows follow completed writes
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= 8'h00;
      cha_q  <= 8'h00;
      chb_q  <= 8'h00;
    end else if (done && apb_in.pwrite) begin
      if (apb_in.paddr == 8'h00) ctrl_q <= apb_in.pwdata[7:0];
      if (apb_in.paddr == 8'h04) cha_q <= apb_in.pwdata[7:0];
      if (apb_in.paddr == 8'h08) chb_q <= apb_in.pwdata[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_one_wait;
    apb_in.psel && !apb_in.penable |=> apb_out.pready ##1 !apb_out.pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready timing wrong");
  property p_unmapped;
    acc && apb_in.paddr > 8'h18 |-> apb_out.pslverr && apb_out.prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access answered");
  property p_rd_ctrl;
    done && !apb_in.pwrite && apb_in.paddr == 8'h00 |-> apb_out.prdata == {24'h00_0000, ctrl_q};
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("clock/run readback wrong");
  property p_rd_cha;
    done && !apb_in.pwrite && apb_in.paddr == 8'h04
      |-> {apb_out.prdata[7:2], apb_out.prdata[0]} == {cha_q[7:2], cha_q[0]};
  endproperty
  a_rd_cha: assert property (p_rd_cha) else $error("channel A readback wrong");
  property p_rd_chb;
    done && !apb_in.pwrite && apb_in.paddr == 8'h08 |-> apb_out.prdata[7:0] == chb_q;
  endproperty
  a_rd_chb: assert property (p_rd_chb) else $error("channel B readback wrong");
  property p_a_float;
    (cha_q[7:6] == 2'h3)[*3] |-> &chan_a_pin_oe_n_out;
  endproperty
  a_a_float: assert property (p_a_float) else $error("channel A driven in timer mode");
  property p_b_float;
    (chb_q[7:6] == 2'h3)[*3] |-> &chan_b_pin_oe_n_out;
  endproperty
  a_b_float: assert property (p_b_float) else $error("channel B driven in timer mode");
  property p_no_change;
    (cha_q[7:4] == 4'h0 && $stable(cha_q) && $stable(ctrl_q[3]))[*4] |-> $stable(chan_a_pin_out);
  endproperty
  a_no_change: assert property (p_no_change) else $error("channel A pin moved");
  // Main scenarios reached
  c_on: cover property (done && apb_in.pwrite && apb_in.paddr == 8'h00 && apb_in.pwdata[3]);
  c_err: cover property (acc && apb_out.pslverr);
  c_capture: cover property (chb_q[7:6] == 2'h1 && ctrl_q[3]);
endmodule
bind enhanced_timer enhanced_timer_props u_props (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
  .apb_in(apb_in), .apb_out(apb_out), .chan_a_pin_out(chan_a_pin_out),
  .chan_a_pin_oe_n_out(chan_a_pin_oe_n_out), .chan_b_pin_oe_n_out(chan_b_pin_oe_n_out));

// file: tb/enhanced_timer_tb_top.sv
/*
  Self-checking bench for the enhanced timer, driven over APB.
  Assumes counter clock code 001, one step per system clock.
*/
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
  err_count++; $display("mismatch %s exp %0h got %0h", nm, exp, got); end end
module enhanced_timer_tb_top;
  import enhanced_timer_pkg::*;
  logic        clk;      // System clock
  logic        rst;      // Reset
  apb_req_s    req;      // Bus request
  apb_rsp_s    rsp;      // Bus answer
  logic [2:0]  b_in;     // Channel B capture inputs
  logic        ext;      // External clock pin level
  logic [1:0]  a_pin;    // Channel A levels
  logic [1:0]  a_oe_n;   // Channel A enables
  logic [2:0]  b_pin;    // Channel B levels
  logic [2:0]  b_oe_n;   // Channel B enables
  logic        slverr;   // Last error answer
  logic [31:0] r;        // Read data
  logic [31:0] c1;       // Count snapshot
  logic [9:0]  mx;       // Highest count seen
  logic        ex;       // Expected pin level
  int          top;      // Expected top count
  int          err_count;
  int          samples_checked;
  enhanced_timer dut (.ref_clk_in(clk), .rst_in(rst), .apb_in(req), .apb_out(rsp),
    .external_clock_pin_in(ext), .subsidiary_clock_in(1'b0), .chan_a_pin_in(2'b00),
    .chan_a_pin_out(a_pin), .chan_a_pin_oe_n_out(a_oe_n), .chan_b_pin_in(b_in),
    .chan_b_pin_out(b_pin), .chan_b_pin_oe_n_out(b_oe_n));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One transfer; holds the request until pready is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    slverr = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  // Off, set both channels, then on
  task automatic run(input logic [7:0] a, input logic [7:0] b, input logic [2:0] p);
    xfer(1'b1, 8'h00, {24'h00_0000, 1'b0, CK_SYS, 1'b0, p});
    xfer(1'b1, 8'h04, {24'h00_0000, a});
    xfer(1'b1, 8'h08, {24'h00_0000, b});
    xfer(1'b1, 8'h00, {24'h00_0000, 1'b0, CK_SYS, 1'b1, p});
  endtask
  // Highest count seen over some 1260 cycles
  task automatic maxcnt;
    mx = 10'h000;
    repeat (180) begin
      xfer(1'b0, 8'h0C, 32'h0000_0000);
      if (r[9:0] > mx) mx = r[9:0];
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    test_done();
  end
  // Main sequence
  initial begin
    req = '0;
    b_in = 3'b000;
    ext = 1'b0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, 8'(4 * i), 32'h0000_0000);
      `CHECK("control reset", 32'h0000_0000, r)
    end
    xfer(1'b0, 8'h1C, 32'h0000_0000);
    `CHECK("unmapped error", 1'b1, slverr)
    // Pause, resume, off and on again
    run(8'h00, 8'h00, 3'h0);
    repeat (20) @(posedge clk);
    xfer(1'b1, 8'h00, {24'h00_0000, 1'b1, CK_SYS, 1'b1, 3'h0});
    xfer(1'b0, 8'h0C, 32'h0000_0000);
    c1 = r;
    repeat (10) @(posedge clk);
    xfer(1'b0, 8'h0C, 32'h0000_0000);
    `CHECK("paused count", c1, r)
    xfer(1'b1, 8'h00, {24'h00_0000, 1'b0, CK_SYS, 1'b1, 3'h0});
    xfer(1'b0, 8'h0C, 32'h0000_0000);
    `CHECK("resumed count", 1'b1, r > c1 && r < c1 + 16)
    xfer(1'b1, 8'h00, {24'h00_0000, 1'b0, CK_SYS, 1'b0, 3'h0});
    xfer(1'b0, 8'h0C, 32'h0000_0000);
    c1 = r;
    repeat (10) @(posedge clk);
    xfer(1'b0, 8'h0C, 32'h0000_0000);
    `CHECK("off count", c1, r)
    xfer(1'b1, 8'h00, {24'h00_0000, 1'b0, CK_SYS, 1'b1, 3'h0});
    xfer(1'b0, 8'h0C, 32'h0000_0000);
    `CHECK("count after on", 1'b1, r < 8)
    // External pin edges clock the counter, rising then falling code
    for (int k = 0; k < 2; k++) begin
      xfer(1'b1, 8'h00, {24'h00_0000, 1'b0, 3'(6 + k), 1'b1, 3'h0});
      xfer(1'b0, 8'h0C, 32'h0000_0000);
      c1 = r;
      ext <= 1'b1;
      repeat (6) @(posedge clk);
      xfer(1'b0, 8'h0C, 32'h0000_0000);
      `CHECK("rising pin count", c1 + 1 - k, r)
      ext <= 1'b0;
      repeat (6) @(posedge clk);
      xfer(1'b0, 8'h0C, 32'h0000_0000);
      `CHECK("falling pin count", c1 + 1, r)
    end
    // Every period value
    for (int p = 0; p < 8; p++) begin
      run(8'h00, 8'h00, 3'(p));
      maxcnt();
      top = (p == 0) ? 1023 : p * 128;
      `CHECK("period top", 1'b1, mx <= top && mx + 10 > top)
    end
    // Comparator A clears the counter, no period flag
    xfer(1'b1, 8'h10, 32'h0000_00C8);
    run(8'h01, 8'h00, 3'h1);
    xfer(1'b1, 8'h18, 32'h0000_0007);
    maxcnt();
    `CHECK("compare A top", 1'b1, mx <= 200 && mx + 10 > 200)
    xfer(1'b0, 8'h18, 32'h0000_0000);
    `CHECK("flags A and P", 2'b01, {r[2], r[0]})
    // Compare-match pins: every function, level and inversion
    xfer(1'b1, 8'h10, 32'h0000_0032);
    for (int i = 0; i < 16; i++) begin
      run({4'(i[1:0]), i[2], i[3], 2'b00}, 8'h00, 3'h0);
      repeat (4) @(posedge clk);
      `CHECK("pin start", {2{i[2] ^ i[3]}}, a_pin)
      repeat (60) @(posedge clk);
      ex = (i[1:0] == 0) ? i[2] : (i[1:0] == 3) ? !i[2] : i[1];
      `CHECK("pin match", {2{ex ^ i[3]}}, a_pin)
    end
    // Timer mode leaves pins undriven; forced PWM levels
    run(8'hC0, 8'hC0, 3'h0);
    repeat (4) @(posedge clk);
    `CHECK("pins released", 5'b1_1111, {a_oe_n, b_oe_n})
    // Comparator A sets the PWM period: only channel B drives
    run(8'h81, 8'h80, 3'h0);
    repeat (4) @(posedge clk);
    `CHECK("PWM period pins", 5'b1_1000, {a_oe_n, b_oe_n})
    for (int f = 0; f < 2; f++) begin
      run(8'hC0, {2'b10, 2'(f), 4'b1000}, 3'h0);
      repeat (4) @(posedge clk);
      `CHECK("forced level", {3{f[0]}}, b_pin)
    end
    // Centre alignment turns at 128; direction flag follows the count
    run(8'hC0, 8'hAB, 3'h1);
    for (int d = 1; d >= 0; d--) begin
      repeat (150) @(posedge clk);
      xfer(1'b0, 8'h04, 32'h0000_0000);
      `CHECK("count direction", d[0], r[1])
    end
    // Capture edges for every code
    for (int f = 0; f < 4; f++) begin
      run(8'hC0, {2'b01, 2'(f), 4'h0}, 3'h0);
      for (int e = 1; e >= 0; e--) begin
        // Compare B out of reach so only a capture can set its flag
        xfer(1'b1, 8'h14, 32'h0000_03FF);
        xfer(1'b1, 8'h18, 32'h0000_0007);
        b_in <= {3{e[0]}};
        repeat (8) @(posedge clk);
        xfer(1'b0, 8'h18, 32'h0000_0000);
        `CHECK("capture flag", f == 2 || f == 1 - e, r[1])
      end
    end
    test_done();
  end
endmodule
